// file: src/bms_pkg.sv
// bms_pkg: constants and types for the bcd mantissa multiply-step datapath
// assumes one 250 MHz clock and firmware that issues one operation at a time
package bms_pkg;
	// ----------------------------------------------------------------
	// mantissa geometry
	// ----------------------------------------------------------------
	localparam int DIGITS = 12; // mantissa width in bcd digits
	localparam int DIG_W = 4; // bits per bcd digit
	localparam int MANT_W = DIGITS * DIG_W; // 48-bit mantissa
	localparam int CNT_W = 16; // count register width
	localparam int CNT_LO = 0; // count digit field, low bit
	localparam int CNT_HI = 3; // count digit field, high bit
	localparam int SBR_SHIFT = 4; // firmware count shift between steps
	localparam logic [3:0] DIGIT_ZERO = 4'h0; // bcd zero digit
	localparam logic [3:0] DIGIT_NINE = 4'h9; // largest legal bcd digit
	localparam logic [3:0] DIGIT_ONE = 4'h1; // decimal carry digit
	localparam logic [3:0] BCD_FIX = 4'h6; // decimal correction addend
	localparam logic [MANT_W-1:0] MANT_ZERO = 48'h0; // cleared mantissa
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0; // cleared count
	// operation codes issued by firmware
	typedef enum logic [1:0] {
		BMS_OP_NONE,
		BMS_OP_MULTIPLY_STEP,
		BMS_OP_SHIFT_OPERAND_ONE,
		BMS_OP_SHIFT_ACCUMULATOR
	} bms_op_type;
endpackage : bms_pkg

// file: src/bms_bcd_adder.sv
// bms_bcd_adder: combinational 12-digit decimal adder with carry in and out
// assumes both operands hold legal bcd digits
`timescale 1ns/1ns
module bms_bcd_adder (
	input wire logic [bms_pkg::MANT_W-1:0] i_a,
	input wire logic [bms_pkg::MANT_W-1:0] i_b,
	input wire logic i_carry,
	output logic [bms_pkg::MANT_W-1:0] o_sum,
	output logic o_carry
);
	// ----------------------------------------------------------------
	// one-digit decimal add with correction
	// ----------------------------------------------------------------
	function automatic logic [4:0] bcd_digit_add(input logic [3:0] a, input logic [3:0] b, input logic c);
		logic [4:0] raw;
		raw = {1'b0, a} + {1'b0, b} + {4'h0, c};
		// correct past nine so the carry moves in base ten
		if (raw > {1'b0, bms_pkg::DIGIT_NINE}) begin
			raw = raw + {1'b0, bms_pkg::BCD_FIX};
			bcd_digit_add = {1'b1, raw[3:0]};
		end else begin
			bcd_digit_add = raw;
		end
	endfunction : bcd_digit_add

	// ripple chain over all digits, low digit first
	always_comb begin
		logic c;
		logic [4:0] d;
		c = i_carry;
		d = 5'h0;
		o_sum = bms_pkg::MANT_ZERO;
		for (int k = 0; k < bms_pkg::DIGITS; k++) begin
			d = bcd_digit_add(i_a[k*bms_pkg::DIG_W +: bms_pkg::DIG_W], i_b[k*bms_pkg::DIG_W +: bms_pkg::DIG_W], c);
			o_sum[k*bms_pkg::DIG_W +: bms_pkg::DIG_W] = d[3:0];
			c = d[4];
		end
		o_carry = c;
	end
endmodule : bms_bcd_adder

// file: src/bms_mult_step.sv
// bms_mult_step: decimal mantissa datapath for multiply step and right shifts
// assumes firmware loads registers, pulses one op, and waits for o_busy low
`timescale 1ns/1ns
module bms_mult_step (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_op_valid, // one-cycle op request
	input wire bms_pkg::bms_op_type i_op, // operation to run
	input wire logic i_load_multiplicand, // load multiplicand_reg
	input wire logic [bms_pkg::MANT_W-1:0] i_multiplicand,
	input wire logic i_load_accumulator, // load accumulator_reg
	input wire logic [bms_pkg::MANT_W-1:0] i_accumulator,
	input wire logic i_load_count, // load count register
	input wire logic [bms_pkg::CNT_W-1:0] i_count,
	input wire logic i_count_shift_right, // firmware count shift by four
	input wire logic i_load_hold, // load digit-holding register
	input wire logic [bms_pkg::CNT_W-1:0] i_hold,
	output logic o_busy, // op in progress
	output logic o_done, // one-cycle pulse at op end
	output logic [bms_pkg::MANT_W-1:0] o_multiplicand_reg,
	output logic [bms_pkg::MANT_W-1:0] o_accumulator_reg,
	output logic [bms_pkg::CNT_W-1:0] o_count,
	output logic [bms_pkg::CNT_W-1:0] o_hold
);
	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BMS_IDLE,
		BMS_MUL,
		BMS_SHIFT
	} bms_state_type;

	bms_state_type state_ff, nxt_state; // sequencer state
	logic [bms_pkg::MANT_W-1:0] mcand_ff, nxt_mcand; // multiplicand_reg
	logic [bms_pkg::MANT_W-1:0] acc_ff, nxt_acc; // accumulator_reg
	logic [bms_pkg::CNT_W-1:0] cnt_ff, nxt_cnt; // count register
	logic [bms_pkg::CNT_W-1:0] hold_ff, nxt_hold; // digit-holding register
	logic [bms_pkg::CNT_W-1:0] left_ff, nxt_left; // iterations remaining
	logic target_acc_ff, nxt_target_acc; // shift targets accumulator
	logic first_ff, nxt_first; // first digit shift of the op
	logic done_ff, nxt_done; // completion pulse
	logic busy_ff, nxt_busy; // op in progress, registered so the output is a flop
	logic [bms_pkg::MANT_W-1:0] sum; // adder result
	logic sum_carry; // adder carry out

	// decimal adder; carry in is unused for the multiply step
	bms_bcd_adder u_adder (
		.i_a(acc_ff),
		.i_b(mcand_ff),
		.i_carry(1'b0),
		.o_sum(sum),
		.o_carry(sum_carry)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one-digit right shift of a mantissa, given digit enters at the top
	function automatic logic [bms_pkg::MANT_W-1:0] shr_digit(input logic [bms_pkg::MANT_W-1:0] m,
			input logic [3:0] d);
		shr_digit = {d, m[bms_pkg::MANT_W-1:bms_pkg::DIG_W]};
	endfunction : shr_digit

	// increment the low digit of the holding register, decimal
	function automatic logic [3:0] digit_inc(input logic [3:0] d);
		digit_inc = (d == bms_pkg::DIGIT_NINE) ? bms_pkg::DIGIT_ZERO : d + bms_pkg::DIGIT_ONE;
	endfunction : digit_inc

	// repeat count digit: for a multiply step only the low nibble of the count register matters; shifts use the whole count
	function automatic logic [3:0] count_digit(input logic [bms_pkg::CNT_W-1:0] c);
		count_digit = c[bms_pkg::CNT_HI:bms_pkg::CNT_LO];
	endfunction : count_digit

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_mcand = mcand_ff;
		nxt_acc = acc_ff;
		nxt_cnt = cnt_ff;
		nxt_hold = hold_ff;
		nxt_left = left_ff;
		nxt_target_acc = target_acc_ff;
		nxt_first = first_ff;
		nxt_done = 1'b0;
		unique case (state_ff)
			BMS_IDLE: begin
				// firmware loads only while idle, so no op sees a torn operand
				if (i_load_multiplicand) begin
					nxt_mcand = i_multiplicand;
				end
				if (i_load_accumulator) begin
					nxt_acc = i_accumulator;
				end
				if (i_load_count) begin
					nxt_cnt = i_count;
				end else if (i_count_shift_right) begin
					nxt_cnt = cnt_ff >> bms_pkg::SBR_SHIFT;
				end
				if (i_load_hold) begin
					nxt_hold = i_hold;
				end
				if (i_op_valid) begin
					unique case (i_op)
						bms_pkg::BMS_OP_MULTIPLY_STEP: begin
							// accumulator kept as is: products build up in place
							nxt_left = {12'h000, count_digit(cnt_ff)};
							// carry digit starts at zero; zero count ends here
							nxt_hold = {hold_ff[bms_pkg::CNT_W-1:bms_pkg::DIG_W], bms_pkg::DIGIT_ZERO};
							if (count_digit(cnt_ff) == bms_pkg::DIGIT_ZERO) begin
								nxt_done = 1'b1;
							end else begin
								nxt_state = BMS_MUL;
							end
						end
						bms_pkg::BMS_OP_SHIFT_OPERAND_ONE, bms_pkg::BMS_OP_SHIFT_ACCUMULATOR: begin
							nxt_left = cnt_ff;
							nxt_target_acc = (i_op == bms_pkg::BMS_OP_SHIFT_ACCUMULATOR);
							nxt_first = 1'b1;
							if (cnt_ff == bms_pkg::CNT_ZERO) begin
								nxt_done = 1'b1;
							end else begin
								nxt_state = BMS_SHIFT;
							end
						end
						bms_pkg::BMS_OP_NONE: begin
							nxt_state = BMS_IDLE;
						end
					endcase
				end
			end
			BMS_MUL: begin
				// one decimal add per cycle; overflow kept at twelve digits
				nxt_acc = sum;
				if (sum_carry) begin
					// carry counts up in the holding digit, wrapping from nine to zero
					nxt_hold = {hold_ff[bms_pkg::CNT_W-1:bms_pkg::DIG_W],
						digit_inc(hold_ff[bms_pkg::DIG_W-1:0])};
				end
				nxt_left = left_ff - 16'h0001;
				if (left_ff == 16'h0001) begin
					nxt_state = BMS_IDLE;
					nxt_done = 1'b1;
				end
			end
			BMS_SHIFT: begin
				// held digit enters only on the first shift, zero after
				if (target_acc_ff) begin
					nxt_acc = shr_digit(acc_ff,
						first_ff ? hold_ff[bms_pkg::DIG_W-1:0] : bms_pkg::DIGIT_ZERO);
					// digit falling off the bottom is kept for rounding
					nxt_hold = {hold_ff[bms_pkg::CNT_W-1:bms_pkg::DIG_W],
						acc_ff[bms_pkg::DIG_W-1:0]};
				end else begin
					nxt_mcand = shr_digit(mcand_ff,
						first_ff ? hold_ff[bms_pkg::DIG_W-1:0] : bms_pkg::DIGIT_ZERO);
				end
				nxt_first = 1'b0;
				nxt_left = left_ff - 16'h0001;
				if (left_ff == 16'h0001) begin
					nxt_state = BMS_IDLE;
					nxt_done = 1'b1;
				end
			end
			default: begin
				nxt_state = BMS_IDLE;
			end
		endcase
		// busy follows the next state, so it rises and falls with the state flop
		// a decoded busy would glitch on state changes; the extra flop avoids that
		nxt_busy = (nxt_state != BMS_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_ff <= BMS_IDLE;
			mcand_ff <= bms_pkg::MANT_ZERO;
			acc_ff <= bms_pkg::MANT_ZERO;
			cnt_ff <= bms_pkg::CNT_ZERO;
			hold_ff <= bms_pkg::CNT_ZERO;
			left_ff <= bms_pkg::CNT_ZERO;
			target_acc_ff <= 1'b0;
			first_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mcand_ff <= nxt_mcand;
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
			hold_ff <= nxt_hold;
			left_ff <= nxt_left;
			target_acc_ff <= nxt_target_acc;
			first_ff <= nxt_first;
			done_ff <= nxt_done;
			busy_ff <= nxt_busy;
		end
	end

	// outputs straight from flip-flops
	// busy and done both come from their own flops, never from decode
	assign o_busy = busy_ff;
	assign o_done = done_ff;
	assign o_multiplicand_reg = mcand_ff;
	assign o_accumulator_reg = acc_ff;
	assign o_count = cnt_ff;
	assign o_hold = hold_ff;
endmodule : bms_mult_step

// file: verif/bms_mult_step_assertions.sv
// checker: port-level timing and value relations of the datapath
// assumes it is bound onto bms_mult_step, one clock, sync reset
`timescale 1ns/1ns
module bms_mult_step_assertions (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_op_valid,
	input wire bms_pkg::bms_op_type i_op,
	input wire logic i_load_accumulator,
	input wire logic i_load_hold,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [bms_pkg::MANT_W-1:0] o_multiplicand_reg,
	input wire logic [bms_pkg::MANT_W-1:0] o_accumulator_reg,
	input wire logic [bms_pkg::CNT_W-1:0] o_count,
	input wire logic [bms_pkg::CNT_W-1:0] o_hold
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic take; // op accepted at this edge
	logic clean; // no accumulator or hold load beside it
	logic [15:0] len_ff, nxt_len; // busy cycles seen
	logic [15:0] want_ff, nxt_want; // busy cycles owed
	assign take = i_op_valid && !o_busy && i_op != bms_pkg::BMS_OP_NONE;
	assign clean = !i_load_accumulator && !i_load_hold;
	// restart on take; multiply owes the low digit, shifts the whole count
	always_comb begin
		nxt_len = take ? 16'h0 : len_ff + 16'(o_busy);
		nxt_want = want_ff;
		if (take) nxt_want = (i_op == bms_pkg::BMS_OP_MULTIPLY_STEP) ? {12'h0, o_count[3:0]} : o_count;
	end
	always_ff @(posedge i_sys_clk) begin
		len_ff <= i_rst_n ? nxt_len : 16'h0;
		want_ff <= i_rst_n ? nxt_want : 16'h0;
	end
	sequence s_mul;
		take && clean && i_op == bms_pkg::BMS_OP_MULTIPLY_STEP;
	endsequence
	sequence s_acc;
		take && clean && i_op == bms_pkg::BMS_OP_SHIFT_ACCUMULATOR && o_count != 16'h0;
	endsequence
	AST_LEN: assert property (o_done |-> len_ff == want_ff)
		else $error("op length differs from count");
	AST_ZERO: assert property (s_mul and o_count[3:0] == 4'h0 |=> o_done && $stable(o_accumulator_reg) && o_hold[3:0] == 4'h0)
		else $error("zero count multiply wrong");
	AST_MUL_START: assert property (s_mul and o_count[3:0] != 4'h0 |=> o_busy && o_hold[3:0] == 4'h0 && $stable(o_accumulator_reg))
		else $error("multiply start wrong");
	AST_CNT: assert property (o_busy |=> $stable(o_count))
		else $error("count moved during op");
	AST_SH_FIRST: assert property (s_acc |-> ##2 o_accumulator_reg == {$past(o_hold[3:0], 2), $past(o_accumulator_reg[47:4], 2)} && o_hold[3:0] == $past(o_accumulator_reg[3:0], 2))
		else $error("first accumulator shift wrong");
	AST_SH_ZERO: assert property (s_acc and o_count > 16'h1 |-> ##3 o_accumulator_reg[47:44] == 4'h0)
		else $error("later shift did not insert zero");
	AST_SH_ONE: assert property (take && clean && i_op == bms_pkg::BMS_OP_SHIFT_OPERAND_ONE && o_count != 16'h0 |-> ##2 o_multiplicand_reg[47:44] == $past(o_hold[3:0], 2) && o_hold == $past(o_hold, 2))
		else $error("operand shift wrong");
	AST_DONE: assert property ($fell(o_busy) |-> o_done)
		else $error("busy fell without done");
endmodule : bms_mult_step_assertions

// file: verif/bms_fw_model.sv
// firmware model: loads operands, issues ops, waits for completion
// assumes one clock shared with the datapath
`timescale 1ns/1ns
module bms_fw_model (
	input wire logic i_sys_clk,
	input wire logic i_done,
	output logic o_op_valid,
	output bms_pkg::bms_op_type o_op,
	output logic o_load,
	output logic o_count_shift_right,
	output logic [47:0] o_mc,
	output logic [47:0] o_acc,
	output logic [15:0] o_count,
	output logic [15:0] o_hold
);
	// idle values at time zero
	initial begin
		{o_op_valid, o_load, o_count_shift_right, o_mc, o_acc, o_count, o_hold} = '0;
		o_op = bms_pkg::BMS_OP_NONE;
	end
	// one-cycle load of all registers while idle
	task automatic load(input logic [47:0] m, input logic [47:0] a, input logic [15:0] c, input logic [15:0] h);
		@(posedge i_sys_clk);
		o_load <= 1'b1;
		o_mc <= m;
		o_acc <= a;
		o_count <= c;
		o_hold <= h;
		@(posedge i_sys_clk);
		o_load <= 1'b0;
	endtask : load
	// expose the next multiplier digit
	task automatic shift_count();
		@(posedge i_sys_clk);
		o_count_shift_right <= 1'b1;
		@(posedge i_sys_clk);
		o_count_shift_right <= 1'b0;
	endtask : shift_count
	// one-cycle request, then bounded wait for done
	task automatic run(input bms_pkg::bms_op_type op, output logic ok);
		ok = 1'b0;
		@(posedge i_sys_clk);
		o_op_valid <= 1'b1;
		o_op <= op;
		@(posedge i_sys_clk);
		o_op_valid <= 1'b0;
		// a zero count answers in the cycle right after the take, so look first
		for (int i = 0; i < 40 && !ok; i++) begin
			#1;
			ok = (i_done === 1'b1);
			if (!ok) @(posedge i_sys_clk);
		end
	endtask : run
endmodule : bms_fw_model

// file: verif/bms_mult_step_tb.sv
// bench: random and corner ops checked against a decimal model
// assumes the firmware model drives every datapath input except clock and reset
`timescale 1ns/1ns
module bms_mult_step_tb;
	logic i_sys_clk, i_rst_n, i_op_valid, ld, i_count_shift_right, o_busy, o_done;
	bms_pkg::bms_op_type i_op;
	logic [47:0] i_multiplicand, i_accumulator, o_multiplicand_reg, o_accumulator_reg;
	logic [15:0] i_count, i_hold, o_count, o_hold;
	int fails = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'hf35b; // fixed seed
	bms_mult_step u_dut (.i_sys_clk, .i_rst_n, .i_op_valid, .i_op, .i_load_multiplicand(ld), .i_multiplicand,
		.i_load_accumulator(ld), .i_accumulator, .i_load_count(ld), .i_count, .i_count_shift_right,
		.i_load_hold(ld), .i_hold, .o_busy, .o_done, .o_multiplicand_reg, .o_accumulator_reg, .o_count, .o_hold);
	bms_fw_model u_fw (.i_sys_clk, .i_done(o_done), .o_op_valid(i_op_valid), .o_op(i_op), .o_load(ld),
		.o_count_shift_right(i_count_shift_right), .o_mc(i_multiplicand), .o_acc(i_accumulator),
		.o_count(i_count), .o_hold(i_hold));
	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [47:0] rbcd();
		logic [47:0] v;
		for (int i = 0; i < 12; i++) v[4*i+:4] = 4'(rnd() % 10);
		return v;
	endfunction : rbcd
	// decimal add, carry out in bit 48
	function automatic logic [48:0] badd(input logic [47:0] a, input logic [47:0] b);
		logic [47:0] r;
		logic [4:0] s;
		logic c;
		c = 1'b0;
		for (int i = 0; i < 12; i++) begin
			s = 5'(a[4*i+:4]) + 5'(b[4*i+:4]) + 5'(c);
			c = s > 5'h9;
			r[4*i+:4] = c ? 4'(s - 5'ha) : s[3:0];
		end
		return {c, r};
	endfunction : badd
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		logic [47:0] m, a, e;
		logic [48:0] t;
		logic [15:0] c, h, eh;
		logic [3:0] d;
		logic ok, mul, acc;
		i_rst_n = 1'b0;
		repeat (6) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 30; k++) begin
			m = rbcd();
			a = rbcd();
			h = 16'(rnd());
			mul = k < 6 || k % 3 == 0;
			acc = k % 3 == 1;
			c = mul ? {12'(rnd()), 4'(rnd() % 10)} : 16'(rnd() % 14);
			if (k == 0) c[3:0] = 4'h0; // zero count corner
			if (k == 1) begin // all nines times nine corner
				m = {12{4'h9}};
				a = m;
				c[3:0] = 4'h9;
			end
			u_fw.load(m, a, c, h);
			u_fw.run(mul ? bms_pkg::BMS_OP_MULTIPLY_STEP : acc ? bms_pkg::BMS_OP_SHIFT_ACCUMULATOR :
				bms_pkg::BMS_OP_SHIFT_OPERAND_ONE, ok);
			if (!ok) begin
				fails++;
				end_sim();
			end
			e = (mul || acc) ? a : m;
			eh = h;
			if (mul) eh[3:0] = 4'h0;
			if (mul) repeat (c[3:0]) begin
				t = badd(e, m);
				e = t[47:0];
				if (t[48]) eh[3:0] = (eh[3:0] == 4'h9) ? 4'h0 : eh[3:0] + 4'h1;
			end
			else for (int i = 0; i < int'(c); i++) begin
				d = e[3:0];
				e = {(i == 0) ? eh[3:0] : 4'h0, e[47:4]};
				if (acc) eh[3:0] = d;
			end
			chk("acc", (mul || acc) ? e : a, o_accumulator_reg);
			chk("mc", (mul || acc) ? m : e, o_multiplicand_reg);
			chk("hold", {32'h0, eh}, {32'h0, o_hold});
			chk("cnt", {32'h0, c}, {32'h0, o_count});
			chk("busy", 48'h0, {47'h0, o_busy});
		end
		u_fw.load(m, a, 16'h4321, h);
		u_fw.shift_count();
		#1;
		chk("cnt shift", {32'h0, 16'h0432}, {32'h0, o_count});
		end_sim();
	end
endmodule : bms_mult_step_tb
bind bms_mult_step bms_mult_step_assertions u_chk (.i_sys_clk, .i_rst_n, .i_op_valid, .i_op,
	.i_load_accumulator, .i_load_hold, .o_busy, .o_done, .o_multiplicand_reg, .o_accumulator_reg, .o_count, .o_hold);
